//--- core/secl_loader.sv
// serial configuration image loader with management read mux and pause control
`timescale 1ns/1ps
module secl_loader
	import secl_pkg::*;
#(
	parameter int FREE_W = 16
) (
	// clock and reset
	input  wire logic              CLK_SYS_IN,
	input  wire logic              RST_N_IN,
	// image memory read port
	output logic                   MEM_RD_REQ_OUT,
	output logic [ADDR_W-1:0]      MEM_ADDR_OUT,
	input  wire logic              MEM_RD_ACK_IN,
	input  wire logic [WORD_W-1:0] MEM_DATA_IN,
	// load status
	output logic                   CFG_DONE_OUT,
	output logic                   ENUM_ENABLE_OUT,
	// flag word decode
	output logic                   SELF_POWERED_FLAG_OUT,
	output logic                   REMOTE_WAKEUP_SUPPORT_OUT,
	output logic                   CHIRP_K_DISABLE_OUT,
	output logic                   SW_PHY_RESET_CONTROL_OUT,
	output logic                   RX_CRC_STRIP_ENABLE_OUT,
	output logic                   TX_CRC_APPEND_ENABLE_OUT,
	output logic                   CAPTURE_EFFECTIVE_ENABLE_OUT,
	// descriptor pointers
	output logic [7:0]             HS_DEV_LEN_OUT,
	output logic [7:0]             HS_DEV_OFS_OUT,
	output logic [7:0]             HS_CFG_LEN_OUT,
	output logic [7:0]             HS_CFG_OFS_OUT,
	output logic [7:0]             FS_DEV_LEN_OUT,
	output logic [7:0]             FS_DEV_OFS_OUT,
	output logic [7:0]             FS_CFG_LEN_OUT,
	output logic [7:0]             FS_CFG_OFS_OUT,
	input  wire logic [2:0]        STR_SEL_IN,
	output logic [7:0]             STR_LEN_OUT,
	output logic [7:0]             STR_OFS_OUT,
	// station identity
	output logic [47:0]            STATION_MAC_OUT,
	output logic [15:0]            LANG_ID_OUT,
	// phy configuration
	output logic [7:0]             PHY_REG_OFS1_OUT,
	output logic [7:0]             PHY_REG_OFS2_OUT,
	output logic [15:0]            MAX_FRAME_OUT,
	output logic [2:0]             PRI_PHY_TYPE_OUT,
	output logic [4:0]             PRI_PHY_MGMT_ADDRESS_OUT,
	output logic [2:0]             SEC_PHY_TYPE_OUT,
	output logic [4:0]             SEC_PHY_MGMT_ADDRESS_OUT,
	// management read mux
	input  wire logic [4:0]        MGMT_PHY_ADDR_IN,
	input  wire logic              EMB_PHY_MDIN_IN,
	input  wire logic              EXT_MDIO_PIN_IN,
	output logic                   MGMT_RD_DATA_OUT,
	// flow control
	input  wire logic              FULL_DUPLEX_IN,
	input  wire logic [FREE_W-1:0] FREE_BYTES_IN,
	output logic                   PAUSE_REQ_OUT
);

	typedef struct packed {
		secl_state_t       state;
		logic [ADDR_W-1:0] addr;
		logic [7:0]        count;
		logic              req;
		logic              done;
		logic [15:0]       flags;
		logic [15:0]       hs_dev;
		logic [15:0]       hs_cfg;
		logic [15:0]       fs_dev;
		logic [15:0]       fs_cfg;
		logic [47:0]       mac;
		logic [15:0]       lang;
		logic [NUM_STRINGS*16-1:0] strs;
		logic [15:0]       phy_reg;
		logic [15:0]       max_pkt;
		logic [15:0]       phy_mgmt_address;
		logic [15:0]       pause_wm;
		logic [7:0]        str_len;
		logic [7:0]        str_ofs;
		logic              mdin_s1;
		logic              mdin_s2;
		logic              mgmt_rd;
	} secl_ld_t;

	secl_ld_t st_q;
	secl_ld_t st_d;
	logic     pause_w;
	logic [2:0] str_idx;

	// string selects past the seven stored entries fall back to the first entry
	assign str_idx = (STR_SEL_IN < 3'(NUM_STRINGS)) ? STR_SEL_IN : 3'h0;

	// fetch sequencer and image latching
	always_comb begin
		st_d = st_q;
		st_d.mdin_s1 = EXT_MDIO_PIN_IN;
		st_d.mdin_s2 = st_q.mdin_s1;
		st_d.mgmt_rd = (MGMT_PHY_ADDR_IN == EMB_PHY_ADDR) ? EMB_PHY_MDIN_IN : st_q.mdin_s2;
		st_d.str_len = st_q.strs[str_idx*16+8 +: 8];
		st_d.str_ofs = st_q.strs[str_idx*16 +: 8];
		case (st_q.state)
			ST_IDLE: begin
				st_d.addr  = WA_COUNT;
				st_d.state = ST_REQ;
			end
			ST_REQ: begin
				st_d.req   = 1'b1;
				st_d.state = ST_WAIT;
			end
			ST_WAIT: begin
				if (MEM_RD_ACK_IN) begin
					st_d.req = 1'b0;
					case (st_q.addr)
						WA_COUNT:   st_d.count = MEM_DATA_IN[7:0];
						WA_FLAG:    st_d.flags = MEM_DATA_IN;
						WA_HS_DEV:  st_d.hs_dev = MEM_DATA_IN;
						WA_HS_CFG:  st_d.hs_cfg = MEM_DATA_IN;
						WA_MAC0:    st_d.mac[15:0] = MEM_DATA_IN;
						WA_MAC1:    st_d.mac[31:16] = MEM_DATA_IN;
						WA_MAC2:    st_d.mac[47:32] = MEM_DATA_IN;
						WA_LANG:    st_d.lang = MEM_DATA_IN;
						WA_PHY_REG: st_d.phy_reg = MEM_DATA_IN;
						WA_MAX_PKT: st_d.max_pkt = MEM_DATA_IN;
						WA_PHY_MGMT_ADDRESS:  st_d.phy_mgmt_address = MEM_DATA_IN;
						WA_PAUSE:   st_d.pause_wm = MEM_DATA_IN;
						WA_FS_DEV:  st_d.fs_dev = MEM_DATA_IN;
						WA_FS_CFG:  st_d.fs_cfg = MEM_DATA_IN;
						default: begin
							if (st_q.addr >= WA_STR_FIRST && st_q.addr <= WA_STR_LAST) begin
								st_d.strs[(st_q.addr - WA_STR_FIRST)*16 +: 16] = MEM_DATA_IN;
							end
						end
					endcase
					if (st_q.addr != WA_COUNT && st_q.addr + 8'h01 >= st_q.count) begin
						st_d.state = ST_DONE;
					end else if (st_q.addr == WA_COUNT && MEM_DATA_IN[7:0] <= 8'h01) begin
						st_d.state = ST_DONE;
					end else begin
						st_d.addr  = st_q.addr + 8'h01;
						st_d.state = ST_REQ;
					end
				end
			end
			ST_DONE: begin
				st_d.done = 1'b1;
			end
			default: st_d.state = ST_IDLE;
		endcase
	end

	// state register
	always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// pause hysteresis only in full duplex after load
	secl_pause_ctl #(
		.FREE_W (FREE_W)
	) u_pause (
		.clk_in        (CLK_SYS_IN),
		.rst_n_in      (RST_N_IN),
		.enable_in     (FULL_DUPLEX_IN & st_q.done),
		.high_mark_in  (st_q.pause_wm[15:8]),
		.low_mark_in   (st_q.pause_wm[7:0]),
		.free_bytes_in (FREE_BYTES_IN),
		.pause_out     (pause_w)
	);

	// outputs, all straight from state flops
	assign MEM_RD_REQ_OUT               = st_q.req;
	assign MEM_ADDR_OUT                 = st_q.addr;
	assign CFG_DONE_OUT                 = st_q.done;
	assign ENUM_ENABLE_OUT              = st_q.done;
	assign SELF_POWERED_FLAG_OUT        = st_q.flags[FB_SELF_PWR];
	assign REMOTE_WAKEUP_SUPPORT_OUT    = st_q.flags[FB_RWU];
	assign CHIRP_K_DISABLE_OUT          = st_q.flags[FB_CHIRP_DIS];
	assign SW_PHY_RESET_CONTROL_OUT     = st_q.flags[FB_SW_PHYRST];
	assign RX_CRC_STRIP_ENABLE_OUT      = st_q.flags[FB_RX_STRIP];
	assign TX_CRC_APPEND_ENABLE_OUT     = st_q.flags[FB_TX_APPEND];
	assign CAPTURE_EFFECTIVE_ENABLE_OUT = st_q.flags[FB_CAPTURE];
	assign HS_DEV_LEN_OUT               = st_q.hs_dev[15:8];
	assign HS_DEV_OFS_OUT               = st_q.hs_dev[7:0];
	assign HS_CFG_LEN_OUT               = st_q.hs_cfg[15:8];
	assign HS_CFG_OFS_OUT               = st_q.hs_cfg[7:0];
	assign FS_DEV_LEN_OUT               = st_q.fs_dev[15:8];
	assign FS_DEV_OFS_OUT               = st_q.fs_dev[7:0];
	assign FS_CFG_LEN_OUT               = st_q.fs_cfg[15:8];
	assign FS_CFG_OFS_OUT               = st_q.fs_cfg[7:0];
	assign STR_LEN_OUT                  = st_q.str_len;
	assign STR_OFS_OUT                  = st_q.str_ofs;
	assign STATION_MAC_OUT              = st_q.mac;
	assign LANG_ID_OUT                  = st_q.lang;
	assign PHY_REG_OFS1_OUT             = st_q.phy_reg[15:8];
	assign PHY_REG_OFS2_OUT             = st_q.phy_reg[7:0];
	assign MAX_FRAME_OUT                = st_q.max_pkt;
	assign PRI_PHY_TYPE_OUT             = st_q.phy_mgmt_address[PHY_TYPE_MSB:PHY_TYPE_LSB];
	assign PRI_PHY_MGMT_ADDRESS_OUT     = st_q.phy_mgmt_address[PHY_ADDR_MSB:0];
	assign SEC_PHY_TYPE_OUT             = st_q.phy_mgmt_address[8+PHY_TYPE_MSB:8+PHY_TYPE_LSB];
	assign SEC_PHY_MGMT_ADDRESS_OUT     = st_q.phy_mgmt_address[8+PHY_ADDR_MSB:8];
	assign MGMT_RD_DATA_OUT             = st_q.mgmt_rd;
	assign PAUSE_REQ_OUT                = pause_w;

endmodule

//--- core/secl_pause_ctl.sv
// pause frame hysteresis controller driven by free buffer space
`timescale 1ns/1ps
module secl_pause_ctl
	import secl_pkg::*;
#(
	parameter int FREE_W = 16
) (
	input  wire logic              clk_in,
	input  wire logic              rst_n_in,
	input  wire logic              enable_in,
	input  wire logic [7:0]        high_mark_in,
	input  wire logic [7:0]        low_mark_in,
	input  wire logic [FREE_W-1:0] free_bytes_in,
	output logic                   pause_out
);

	// elaboration check: a scaled high mark must fit the free-space width
	if (FREE_W < WM_UNIT_SHIFT + 8) begin : g_bad_free_w
		$error("free space width too narrow for watermark units");
	end

	typedef struct packed {
		logic pause;
	} secl_pc_t;

	secl_pc_t st_q;
	secl_pc_t st_d;
	logic [FREE_W-1:0] hi_bytes;
	logic [FREE_W-1:0] lo_bytes;

	// marks scaled to bytes, zero-extended into the free-space width
	assign hi_bytes = FREE_W'({high_mark_in, 8'h00});
	assign lo_bytes = FREE_W'({low_mark_in, 8'h00});

	always_comb begin
		st_d = st_q;
		if (!enable_in) begin
			st_d.pause = 1'b0;
		end else if (!st_q.pause && free_bytes_in <= hi_bytes) begin
			st_d.pause = 1'b1;
		end else if (st_q.pause && free_bytes_in >= lo_bytes) begin
			st_d.pause = 1'b0;
		end
	end

	// state register
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign pause_out = st_q.pause;

endmodule

//--- core/secl_pkg.sv
// shared constants for the serial configuration image loader
package secl_pkg;

	// image word addresses
	localparam logic [7:0] WA_COUNT     = 8'h00;
	localparam logic [7:0] WA_FLAG      = 8'h01;
	localparam logic [7:0] WA_HS_DEV    = 8'h02;
	localparam logic [7:0] WA_HS_CFG    = 8'h03;
	localparam logic [7:0] WA_MAC0      = 8'h04;
	localparam logic [7:0] WA_MAC1      = 8'h05;
	localparam logic [7:0] WA_MAC2      = 8'h06;
	localparam logic [7:0] WA_LANG      = 8'h07;
	localparam logic [7:0] WA_STR_FIRST = 8'h08;
	localparam logic [7:0] WA_STR_LAST  = 8'h0E;
	localparam logic [7:0] WA_PHY_REG   = 8'h0F;
	localparam logic [7:0] WA_MAX_PKT   = 8'h10;
	localparam logic [7:0] WA_PHY_MGMT_ADDRESS    = 8'h11;
	localparam logic [7:0] WA_PAUSE     = 8'h12;
	localparam logic [7:0] WA_FS_DEV    = 8'h13;
	localparam logic [7:0] WA_FS_CFG    = 8'h14;

	// expected preload count
	localparam logic [7:0] PRELOAD_COUNT = 8'h15;
	localparam int         NUM_STRINGS   = 7;

	// flag word bit positions
	localparam int FB_SELF_PWR  = 0;
	localparam int FB_RWU       = 2;
	localparam int FB_CHIRP_DIS = 4;
	localparam int FB_SW_PHYRST = 5;
	localparam int FB_RX_STRIP  = 6;
	localparam int FB_TX_APPEND = 7;
	localparam int FB_CAPTURE   = 8;

	// phy descriptor fields and embedded phy address
	localparam int         PHY_TYPE_MSB  = 7;
	localparam int         PHY_TYPE_LSB  = 5;
	localparam int         PHY_ADDR_MSB  = 4;
	localparam logic [4:0] EMB_PHY_ADDR  = 5'h10;

	// watermark unit is 256 bytes: shift left by eight
	localparam int WM_UNIT_SHIFT = 8;

	// word and pointer widths
	localparam int WORD_W = 16;
	localparam int ADDR_W = 8;

	typedef enum logic [1:0] {ST_IDLE, ST_REQ, ST_WAIT, ST_DONE} secl_state_t;

endpackage

//--- verif/secl_eeprom_model.sv
// behavioural image memory answering the loader's word reads
`timescale 1ns/1ps
module secl_eeprom_model (
	// clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	// word read port
	input  wire logic        rd_req_in,
	input  wire logic [7:0]  addr_in,
	input  wire logic [3:0]  wait_in,
	output logic             ack_out,
	output logic [15:0]      data_out
);
	logic [15:0] mem [0:31];
	logic [3:0]  cnt_q;

	// answer after wait_in cycles; data toggles when not acked so stale words never match
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ack_out  <= 1'b0;
			cnt_q    <= 4'h0;
			data_out <= 16'hA5A5;
		end else if (rd_req_in && !ack_out && cnt_q >= wait_in) begin
			ack_out  <= 1'b1;
			cnt_q    <= 4'h0;
			data_out <= mem[addr_in[4:0]];
		end else begin
			ack_out  <= 1'b0;
			cnt_q    <= (rd_req_in && !ack_out) ? cnt_q + 4'h1 : 4'h0;
			data_out <= ~data_out;
		end
	end
endmodule

//--- verif/secl_loader_chk.sv
// port-level assertions for the configuration image loader
`timescale 1ns/1ps
module secl_loader_chk
	import secl_pkg::*;
#(
	parameter int FREE_W = 16
) (
	// clock, reset and image port
	input wire logic              CLK_SYS_IN,
	input wire logic              RST_N_IN,
	input wire logic              MEM_RD_REQ_OUT,
	input wire logic [ADDR_W-1:0] MEM_ADDR_OUT,
	input wire logic              MEM_RD_ACK_IN,
	input wire logic [WORD_W-1:0] MEM_DATA_IN,
	input wire logic              CFG_DONE_OUT,
	input wire logic              ENUM_ENABLE_OUT,
	// management mux
	input wire logic [4:0]        MGMT_PHY_ADDR_IN,
	input wire logic              EMB_PHY_MDIN_IN,
	input wire logic              EXT_MDIO_PIN_IN,
	input wire logic              MGMT_RD_DATA_OUT,
	// flow control
	input wire logic              FULL_DUPLEX_IN,
	input wire logic [FREE_W-1:0] FREE_BYTES_IN,
	input wire logic              PAUSE_REQ_OUT
);
	logic [7:0] hi_q;
	logic [7:0] lo_q;
	logic       take;
	logic       on;

	// shadow of the watermarks, since they are not visible at the ports
	assign take = MEM_RD_REQ_OUT && MEM_RD_ACK_IN && MEM_ADDR_OUT == WA_PAUSE;
	assign on = FULL_DUPLEX_IN && CFG_DONE_OUT;
	always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			hi_q <= 8'h00;
			lo_q <= 8'h00;
		end else if (take) begin
			hi_q <= MEM_DATA_IN[15:8];
			lo_q <= MEM_DATA_IN[7:0];
		end
	end

	default clocking @(posedge CLK_SYS_IN); endclocking
	default disable iff (!RST_N_IN);

	chk_first_read: assert property ($rose(RST_N_IN) |-> ##[1:3] MEM_RD_REQ_OUT && MEM_ADDR_OUT == 8'h00)
		else $error("first read missing");
	chk_req_hold: assert property (MEM_RD_REQ_OUT && !MEM_RD_ACK_IN |=> MEM_RD_REQ_OUT && $stable(MEM_ADDR_OUT))
		else $error("read request dropped");
	chk_addr_step: assert property (MEM_RD_REQ_OUT && MEM_RD_ACK_IN |=> ##1 (MEM_RD_REQ_OUT -> MEM_ADDR_OUT == $past(MEM_ADDR_OUT, 2) + 8'h01))
		else $error("read address not sequential");
	chk_done_last: assert property (take == 1'b0 && MEM_RD_REQ_OUT && MEM_RD_ACK_IN && MEM_ADDR_OUT == WA_FS_CFG |=> !CFG_DONE_OUT ##[1:2] CFG_DONE_OUT)
		else $error("done not after last word");
	chk_done_quiet: assert property (CFG_DONE_OUT |-> !MEM_RD_REQ_OUT && ENUM_ENABLE_OUT)
		else $error("reading after done");
	chk_enum_gate: assert property (!CFG_DONE_OUT |-> !ENUM_ENABLE_OUT)
		else $error("enumeration before load");
	chk_mux_emb: assert property (MGMT_PHY_ADDR_IN == EMB_PHY_ADDR |=> MGMT_RD_DATA_OUT == $past(EMB_PHY_MDIN_IN))
		else $error("embedded read data wrong");
	chk_mux_ext: assert property (MGMT_PHY_ADDR_IN != EMB_PHY_ADDR |=> MGMT_RD_DATA_OUT == $past(EXT_MDIO_PIN_IN, 3))
		else $error("pin read data wrong");
	chk_pause_off: assert property (!on |=> !PAUSE_REQ_OUT)
		else $error("pause outside full duplex");
	chk_pause_set: assert property (on && FREE_BYTES_IN <= FREE_W'({hi_q, 8'h00}) |=> PAUSE_REQ_OUT)
		else $error("pause not raised");
	chk_pause_clr: assert property (on && FREE_BYTES_IN >= FREE_W'({lo_q, 8'h00}) && FREE_BYTES_IN > FREE_W'({hi_q, 8'h00}) |=> !PAUSE_REQ_OUT)
		else $error("pause not cleared");

	cover property (CFG_DONE_OUT);
	cover property (PAUSE_REQ_OUT);
	cover property (MGMT_PHY_ADDR_IN == EMB_PHY_ADDR && MGMT_RD_DATA_OUT);
endmodule

bind secl_loader secl_loader_chk #(.FREE_W(FREE_W)) u_secl_loader_chk (
	.CLK_SYS_IN(CLK_SYS_IN), .RST_N_IN(RST_N_IN), .MEM_RD_REQ_OUT(MEM_RD_REQ_OUT),
	.MEM_ADDR_OUT(MEM_ADDR_OUT), .MEM_RD_ACK_IN(MEM_RD_ACK_IN), .MEM_DATA_IN(MEM_DATA_IN),
	.CFG_DONE_OUT(CFG_DONE_OUT), .ENUM_ENABLE_OUT(ENUM_ENABLE_OUT),
	.MGMT_PHY_ADDR_IN(MGMT_PHY_ADDR_IN), .EMB_PHY_MDIN_IN(EMB_PHY_MDIN_IN),
	.EXT_MDIO_PIN_IN(EXT_MDIO_PIN_IN), .MGMT_RD_DATA_OUT(MGMT_RD_DATA_OUT),
	.FULL_DUPLEX_IN(FULL_DUPLEX_IN), .FREE_BYTES_IN(FREE_BYTES_IN), .PAUSE_REQ_OUT(PAUSE_REQ_OUT)
);

//--- verif/secl_loader_tb_top.sv
// self-checking bench for the configuration image loader
`timescale 1ns/1ps
module secl_loader_tb_top
	import secl_pkg::*;
;
	logic        clk, rst_n, emb, ext, fd;
	logic [15:0] free;
	logic [4:0]  maddr;
	logic [2:0]  sel;
	logic [3:0]  wt;
	wire logic        req, ack, done, enb, mout, pause;
	wire logic [7:0]  addr, hdl, hdo, hcl, hco, fdl, fdo, fcl, fco, sl, so, r1, r2;
	wire logic [15:0] data, lang, maxf;
	wire logic [6:0]  flg;
	wire logic [47:0] mac;
	wire logic [2:0]  pt, st;
	wire logic [4:0]  pa, sa;
	int          failures = 0;
	int          samples_checked = 0;
	int          cyc = 0;

	secl_loader u_secl_loader (
		.CLK_SYS_IN(clk), .RST_N_IN(rst_n), .MEM_RD_REQ_OUT(req), .MEM_ADDR_OUT(addr),
		.MEM_RD_ACK_IN(ack), .MEM_DATA_IN(data), .CFG_DONE_OUT(done), .ENUM_ENABLE_OUT(enb),
		.SELF_POWERED_FLAG_OUT(flg[0]), .REMOTE_WAKEUP_SUPPORT_OUT(flg[1]),
		.CHIRP_K_DISABLE_OUT(flg[2]), .SW_PHY_RESET_CONTROL_OUT(flg[3]),
		.RX_CRC_STRIP_ENABLE_OUT(flg[4]), .TX_CRC_APPEND_ENABLE_OUT(flg[5]),
		.CAPTURE_EFFECTIVE_ENABLE_OUT(flg[6]), .HS_DEV_LEN_OUT(hdl), .HS_DEV_OFS_OUT(hdo),
		.HS_CFG_LEN_OUT(hcl), .HS_CFG_OFS_OUT(hco), .FS_DEV_LEN_OUT(fdl), .FS_DEV_OFS_OUT(fdo),
		.FS_CFG_LEN_OUT(fcl), .FS_CFG_OFS_OUT(fco), .STR_SEL_IN(sel), .STR_LEN_OUT(sl),
		.STR_OFS_OUT(so), .STATION_MAC_OUT(mac), .LANG_ID_OUT(lang), .PHY_REG_OFS1_OUT(r1),
		.PHY_REG_OFS2_OUT(r2), .MAX_FRAME_OUT(maxf), .PRI_PHY_TYPE_OUT(pt),
		.PRI_PHY_MGMT_ADDRESS_OUT(pa), .SEC_PHY_TYPE_OUT(st), .SEC_PHY_MGMT_ADDRESS_OUT(sa),
		.MGMT_PHY_ADDR_IN(maddr), .EMB_PHY_MDIN_IN(emb), .EXT_MDIO_PIN_IN(ext),
		.MGMT_RD_DATA_OUT(mout), .FULL_DUPLEX_IN(fd), .FREE_BYTES_IN(free), .PAUSE_REQ_OUT(pause)
	);
	secl_eeprom_model u_secl_eeprom_model (
		.clk_in(clk), .rst_n_in(rst_n), .rd_req_in(req), .addr_in(addr), .wait_in(wt),
		.ack_out(ack), .data_out(data)
	);

	// 250 MHz system clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// hang guard, far above the few hundred cycles the scenarios need
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			final_report();
		end
	end

	task automatic chk(input string nm, input logic [47:0] seen, input logic [47:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	// inputs always move 1 ns after the rising edge
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic load_run();
		int k;
		rst_n = 1'b0;
		tick(5);
		rst_n = 1'b1;
		k = 0;
		chk("enum_early", enb, 1'b0);
		while (done !== 1'b1 && k < 1000) begin
			tick(1);
			k++;
		end
		chk("cfg_done", done, 1'b1);
	endtask

	task automatic t_load(input logic [3:0] w, input logic [15:0] x);
		logic [15:0] v;
		for (int i = 0; i < 32; i++) u_secl_eeprom_model.mem[i] = 16'(i * 16'h1357) ^ x;
		u_secl_eeprom_model.mem[0] = {x[15:8], 8'h15};
		u_secl_eeprom_model.mem[18] = 16'h0410;
		wt = w;
		load_run();
		chk("enum", enb, 1'b1);
		v = u_secl_eeprom_model.mem[1];
		chk("flags", flg, {v[8], v[7:4], v[2], v[0]});
		chk("hs_dev", {hdl, hdo}, u_secl_eeprom_model.mem[2]);
		chk("hs_cfg", {hcl, hco}, u_secl_eeprom_model.mem[3]);
		chk("mac", mac, {u_secl_eeprom_model.mem[6], u_secl_eeprom_model.mem[5],
			u_secl_eeprom_model.mem[4]});
		chk("lang", lang, u_secl_eeprom_model.mem[7]);
		chk("phy_reg", {r1, r2}, u_secl_eeprom_model.mem[15]);
		chk("max_frame", maxf, u_secl_eeprom_model.mem[16]);
		chk("phy_ids", {st, sa, pt, pa}, u_secl_eeprom_model.mem[17]);
		chk("fs_dev", {fdl, fdo}, u_secl_eeprom_model.mem[19]);
		chk("fs_cfg", {fcl, fco}, u_secl_eeprom_model.mem[20]);
		// select 7 has no entry of its own and falls back to the first string
		for (int s = 0; s < 8; s++) begin
			sel = 3'(s);
			tick(2);
			chk("string", {sl, so}, u_secl_eeprom_model.mem[s < NUM_STRINGS ? 8 + s : 8]);
		end
	endtask

	// marks 04h and 10h: pause at 1024 free bytes, release at 4096
	task automatic t_pause();
		fd = 1'b1;
		free = 16'h0401;
		tick(2);
		chk("pause_above", pause, 1'b0);
		free = 16'h0400;
		tick(1);
		chk("pause_high", pause, 1'b1);
		free = 16'h0FFF;
		tick(2);
		chk("pause_band", pause, 1'b1);
		free = 16'h1000;
		tick(1);
		chk("pause_low", pause, 1'b0);
		free = 16'h0000;
		tick(1);
		chk("pause_again", pause, 1'b1);
		// leaving full duplex must drop a pause that is standing
		fd = 1'b0;
		tick(1);
		chk("pause_half", pause, 1'b0);
	endtask

	task automatic t_mux();
		maddr = EMB_PHY_ADDR;
		emb = 1'b1;
		tick(1);
		chk("mux_emb", mout, 1'b1);
		emb = 1'b0;
		ext = 1'b1;
		tick(3);
		chk("mux_emb_only", mout, 1'b0);
		maddr = 5'h00;
		tick(1);
		chk("mux_ext", mout, 1'b1);
		emb = 1'b1;
		ext = 1'b0;
		maddr = 5'h11;
		tick(3);
		chk("mux_ext_low", mout, 1'b0);
	endtask

	// count 2 with junk high byte: only words 00H and 01H are read
	task automatic t_short();
		u_secl_eeprom_model.mem[0] = 16'hFF02;
		load_run();
		chk("short_hs_dev", {hdl, hdo}, 16'h0000);
		chk("short_mac", mac, 48'h0);
	endtask

	initial begin
		rst_n = 1'b0;
		emb = 1'b0;
		ext = 1'b0;
		fd = 1'b0;
		free = 16'hFFFF;
		maddr = 5'h00;
		sel = 3'h0;
		wt = 4'h0;
		tick(1);
		t_load(4'h0, 16'h0000);
		t_pause();
		t_mux();
		t_load(4'h5, 16'hFFFF);
		t_short();
		final_report();
	end
endmodule
